// ### src/ahp_pkg.sv
package ahp_pkg;

    // Serial word and conversion result sizes.
    localparam int WORD_W = 16;
    localparam int RES_W = 12;
    localparam int CHAN_W = 3;
    localparam int FIFO_DEPTH = 32;
    localparam logic [4:0] BITS_PER_WORD = 5'h10;

    // Control word layout.
    localparam int CHAN_LSB = 13;
    localparam int SW_START_BIT = 12;
    localparam int TWO_WIRE_BIT = 11;
    localparam logic [WORD_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] WRITE_NOP = 16'h0000;

    // Conversion time counted in master clock periods, rounded down.
    localparam int CONV_TIME_NS = 4600;
    localparam int MCLK_IN_KHZ = 4000;
    localparam int CONV_MCLK_PERIODS = CONV_TIME_NS * MCLK_IN_KHZ / 1000000;
    localparam logic [4:0] CONV_LAST = 5'(CONV_MCLK_PERIODS - 1);

    typedef struct packed {
        logic [1:0] sclk_s;
        logic [1:0] sync_s;
        logic [1:0] din_s;
        logic [1:0] cnv_s;
        logic [1:0] mck_s;
        logic sclk_prev;
        logic sync_prev;
        logic cnv_prev;
        logic mck_prev;
        logic [4:0] bit_cnt;
        logic [WORD_W-1:0] rx;
        logic [WORD_W-1:0] tx;
        logic rd_phase;
        logic [WORD_W-1:0] ctrl;
        logic busy;
        logic [4:0] conv_cnt;
        logic [RES_W-1:0] sample;
        logic [RES_W-1:0] last_res;
        logic push;
        logic dout;
        logic dout_oe_n;
        logic din_o;
        logic din_oe_n;
    } ahp_state_t;

endpackage

// ### src/ahp_port.sv
// Operation
// - Three-wire mode: shift in control word while shifting out previous result.
// - An all-zero write word changes no register.
// - Busy falling clears software start bit; it is only accepted afterwards.
// - A conversion completes within 4.6 us at a 4 MHz master clock.
// - Device drives busy to mark conversion; host may ignore it.
// - Frame select low enables output in three-wire mode; first falling edge gives leading zero.
// - Serial input is sampled on the rising serial clock edge.
// - Frame select high then low resets the serial framing.

module ahp_fifo #(
    parameter int W = 12,
    parameter int D = 32
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Filling side
    input wire logic i_in_valid,
    input wire logic [W-1:0] i_in_data,
    output logic o_in_ready,
    // Draining side
    output logic o_out_valid,
    output logic [W-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic do_wr;
    logic do_rd;

    assign o_in_ready = (cnt_q != (AW+1)'(D));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem_q[rd_q];
    assign do_wr = i_in_valid & o_in_ready;
    assign do_rd = i_out_ready & o_out_valid;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    // Storage carries no reset so it maps onto plain flip-flops without a reset tree.
    always_ff @(posedge i_mclk) begin
        if (do_wr) begin
            mem_q[wr_q] <= i_in_data;
        end
    end
endmodule

module ahp_port
    import ahp_pkg::*;
(
    // System clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Serial pins
    input wire logic i_sclk,
    input wire logic i_sync_n,
    input wire logic i_din,
    output logic o_din,
    output logic o_din_oe_n,
    output logic o_dout,
    output logic o_dout_oe_n,
    // Conversion control pins
    input wire logic i_conversion_start_n,
    input wire logic i_master_clock_in,
    output logic o_busy,
    // Converter core side
    input wire logic [RES_W-1:0] i_sample,
    output logic [WORD_W-1:0] o_ctrl,
    output logic [CHAN_W-1:0] o_channel,
    output logic o_two_wire
);
    ahp_state_t q;
    ahp_state_t n;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RES_W-1:0] fifo_out_data;
    logic pop;
    logic rise;
    logic fall;
    logic mck_rise;
    logic cnv_fall;
    logic two_wire;
    logic word_done;

    ahp_fifo #(.W(RES_W), .D(FIFO_DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_in_valid(q.push),
        .i_in_data(q.sample),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out_data),
        .i_out_ready(pop)
    );

    always_comb begin
        n = q;
        pop = 1'b0;
        n.push = 1'b0;
        n.sclk_s = {q.sclk_s[0], i_sclk};
        n.sync_s = {q.sync_s[0], i_sync_n};
        n.din_s = {q.din_s[0], i_din};
        n.cnv_s = {q.cnv_s[0], i_conversion_start_n};
        n.mck_s = {q.mck_s[0], i_master_clock_in};
        n.sclk_prev = q.sclk_s[1];
        n.sync_prev = q.sync_s[1];
        n.cnv_prev = q.cnv_s[1];
        n.mck_prev = q.mck_s[1];
        rise = q.sclk_s[1] & ~q.sclk_prev;
        fall = ~q.sclk_s[1] & q.sclk_prev;
        mck_rise = q.mck_s[1] & ~q.mck_prev;
        cnv_fall = ~q.cnv_s[1] & q.cnv_prev;
        two_wire = q.ctrl[TWO_WIRE_BIT];
        word_done = 1'b0;

        // Conversion timing runs on master clock edges.
        if (q.busy && mck_rise) begin
            n.conv_cnt = q.conv_cnt + 5'h01;
            if (q.conv_cnt == CONV_LAST) begin
                n.busy = 1'b0;
                n.push = 1'b1;
                n.ctrl[SW_START_BIT] = 1'b0;
            end
        end
        // A start landing on the finishing cycle takes its sample one cycle late, after the
        // finished result has been queued, so the queued result is never overwritten.
        if (q.push && q.busy) begin
            n.sample = i_sample;
        end
        // The start pin is refused while busy or while no result slot is free.
        if (cnv_fall && !n.busy && fifo_in_ready) begin
            n.busy = 1'b1;
            n.conv_cnt = '0;
            if (!n.push) begin
                n.sample = i_sample;
            end
        end

        if (q.sync_s[1]) begin
            n.bit_cnt = '0;
            n.dout_oe_n = 1'b1;
            n.din_oe_n = 1'b1;
        end else begin
            if (q.sync_prev) begin
                n.bit_cnt = '0;
                n.dout_oe_n = two_wire;
                n.din_oe_n = ~(two_wire & q.rd_phase);
                n.dout = 1'b0;
                if (fifo_out_valid) begin
                    pop = 1'b1;
                    n.last_res = fifo_out_data;
                    n.tx = {4'h0, fifo_out_data};
                end else begin
                    n.tx = {4'h0, q.last_res};
                end
            end
            if (rise && q.bit_cnt != BITS_PER_WORD) begin
                n.rx = {q.rx[WORD_W-2:0], q.din_s[1]};
                n.bit_cnt = q.bit_cnt + 5'h01;
                if (q.bit_cnt == BITS_PER_WORD - 5'h01) begin
                    word_done = ~(two_wire & q.rd_phase);
                    if (two_wire) begin
                        // Two-wire frames alternate write and read, even with select held low.
                        n.bit_cnt = '0;
                        n.rd_phase = ~q.rd_phase;
                        n.din_oe_n = q.rd_phase;
                        if (!q.rd_phase) begin
                            n.tx = {4'h0, q.last_res};
                        end
                    end
                end
            end
            if (fall && q.bit_cnt != BITS_PER_WORD && (!two_wire || q.rd_phase)) begin
                n.dout = q.tx[WORD_W-1];
                n.din_o = q.tx[WORD_W-1];
                n.tx = {q.tx[WORD_W-2:0], 1'b0};
            end
        end

        if (word_done && n.rx != WRITE_NOP) begin
            n.ctrl = n.rx;
            if (n.rx[TWO_WIRE_BIT] != two_wire) begin
                n.rd_phase = 1'b0;
            end
            if (n.rx[SW_START_BIT]) begin
                if (!n.busy && fifo_in_ready) begin
                    n.busy = 1'b1;
                    n.conv_cnt = '0;
                    if (!n.push) begin
                        n.sample = i_sample;
                    end
                end else begin
                    // A refused start leaves no stale request behind in the register.
                    n.ctrl[SW_START_BIT] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{sclk_s: 2'h3, sync_s: 2'h3, cnv_s: 2'h3, sclk_prev: 1'b1,
                   sync_prev: 1'b1, cnv_prev: 1'b1, ctrl: CTRL_RESET,
                   dout_oe_n: 1'b1, din_oe_n: 1'b1, default: '0};
        end else begin
            q <= n;
        end
    end

    always_comb begin
        o_dout = q.dout;
        o_dout_oe_n = q.dout_oe_n;
        o_din = q.din_o;
        o_din_oe_n = q.din_oe_n;
        o_busy = q.busy;
        o_ctrl = q.ctrl;
        o_channel = q.ctrl[CHAN_LSB +: CHAN_W];
        o_two_wire = q.ctrl[TWO_WIRE_BIT];
    end
endmodule

// ### dv/ahp_port_props.sv
module ahp_port_props
    import ahp_pkg::*;
(
    // Clock, reset and frame select
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_sync_n,
    // Observed outputs
    input wire logic o_dout,
    input wire logic o_dout_oe_n,
    input wire logic o_busy,
    input wire logic [WORD_W-1:0] o_ctrl,
    input wire logic [CHAN_W-1:0] o_channel,
    input wire logic o_two_wire
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence s_conv_end;
        ##[1:120] !o_busy;
    endsequence
    sequence s_oe_off;
        ##[1:4] o_dout_oe_n;
    endsequence
    a_chan_field: assert property (o_channel == o_ctrl[15:13])
        else $error("channel field wrong");
    a_mode_field: assert property (o_two_wire && $fell(i_sync_n) |-> o_dout_oe_n[*4])
        else $error("output driven in two-wire mode");
    a_start_busy: assert property ($rose(o_ctrl[12]) |-> ##[0:2] o_busy)
        else $error("start bit did not launch");
    a_busy_clears: assert property ($fell(o_busy) |-> !o_ctrl[12])
        else $error("start bit kept after busy");
    a_conv_bound: assert property ($rose(o_busy) |-> s_conv_end)
        else $error("conversion too long");
    a_busy_holds: assert property ($rose(o_busy) |-> o_busy[*8])
        else $error("busy pulse too short");
    a_dout_on: assert property ($fell(i_sync_n) && !o_two_wire |-> ##[1:4] !o_dout_oe_n)
        else $error("output not enabled");
    a_dout_off: assert property ($rose(i_sync_n) |-> s_oe_off)
        else $error("output not released");
    a_lead_zero: assert property ($fell(o_dout_oe_n) |-> !o_dout)
        else $error("first bit not zero");
endmodule

bind ahp_port ahp_port_props u_props (.i_mclk, .i_rst_n, .i_sync_n, .o_dout, .o_dout_oe_n,
    .o_busy, .o_ctrl, .o_channel, .o_two_wire);

// ### dv/ahp_host_model.sv
module ahp_host_model
    import ahp_pkg::*;
(
    // Host pins
    output logic o_sclk,
    output logic o_sync_n,
    output logic o_din,
    // Lines read back
    input wire logic i_dout,
    input wire logic i_din_wire
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_sclk = 1'b1;
        o_sync_n = 1'b1;
        o_din = 1'b0;
    end
    // A released line toggles so that a stale value is never read as data.
    task automatic xfer(input logic [WORD_W-1:0] w, input int n, input bit rd,
                        output logic [WORD_W-1:0] got);
        got = '0;
        o_sync_n = 1'b0;
        #200;
        for (int i = 0; i < n; i++) begin
            o_sclk = 1'b0;
            o_din = rd ? ~o_din : (i < WORD_W ? w[WORD_W-1-i] : 1'b1);
            #200;
            o_sclk = 1'b1;
            if (i < WORD_W) got = {got[WORD_W-2:0], rd ? i_din_wire : i_dout};
            #200;
        end
        o_sync_n = 1'b1;
        o_din = ~o_din;
        #400;
    endtask
endmodule

// ### dv/tb_adc_serial_host_port.sv
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb_adc_serial_host_port import ahp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rst_n = 1'b0, cnv_n = 1'b1, mck = 1'b0;
    logic sclk, sync_n, hdin, din_w, din_o, din_oe_n, dout, dout_oe_n, busy, two, dout_w;
    logic [RES_W-1:0] sample = '0;
    logic [WORD_W-1:0] ctrl, got;
    logic [CHAN_W-1:0] chan;
    int n_mismatch = 0, checked = 0, cyc = 0;
    initial forever #25 mclk = ~mclk;
    initial forever #125 mck = ~mck;
    assign din_w = din_oe_n ? hdin : din_o;
    // A released output shows the inverse of its last value, so a missing enable spoils a read.
    assign dout_w = dout_oe_n ? ~dout : dout;
    ahp_port dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_sclk(sclk), .i_sync_n(sync_n),
        .i_din(din_w), .o_din(din_o), .o_din_oe_n(din_oe_n), .o_dout(dout),
        .o_dout_oe_n(dout_oe_n), .i_conversion_start_n(cnv_n), .i_master_clock_in(mck),
        .o_busy(busy), .i_sample(sample), .o_ctrl(ctrl), .o_channel(chan), .o_two_wire(two));
    ahp_host_model host (.o_sclk(sclk), .o_sync_n(sync_n), .o_din(hdin), .i_dout(dout_w),
        .i_din_wire(din_w));
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic pin_start(input logic [RES_W-1:0] s);
        @(negedge mclk);
        sample = s;
        cnv_n = 1'b0;
        repeat (2) @(negedge mclk);
        cnv_n = 1'b1;
        repeat (3) @(negedge mclk);
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge mclk);
    endtask
    task automatic frame(input logic [WORD_W-1:0] w, input int n, input bit rd);
        @(negedge mclk);
        host.xfer(w, n, rd, got);
        repeat (4) @(negedge mclk);
    endtask
    task automatic t_nop;
        frame(WRITE_NOP, 16, 1'b0);
        `CHK("nop ctrl", CTRL_RESET, ctrl);
        `CHK("empty word", 16'h0000, got);
    endtask
    task automatic t_fifo;
        for (int k = 0; k < FIFO_DEPTH; k++) begin
            pin_start(12'h100 + 12'(k));
            `CHK("busy", 1'b1, busy);
            wait_idle();
            `CHK("done", 1'b0, busy);
        end
        pin_start(12'hFFF);
        `CHK("full refused", 1'b0, busy);
        for (int k = 0; k <= FIFO_DEPTH; k++) begin
            frame(WRITE_NOP, 16, 1'b0);
            `CHK("result", {4'h0, 12'h100 + 12'(k < FIFO_DEPTH ? k : k - 1)}, got);
        end
    endtask
    task automatic t_sw;
        sample = 12'h3C3;
        frame(16'hA000, 16, 1'b0);
        `CHK("channel", 3'h5, chan);
        `CHK("no start", 1'b0, busy);
        frame(16'hB000, 16, 1'b0);
        `CHK("sw busy", 1'b1, busy);
        wait_idle();
        `CHK("start cleared", 16'hA000, ctrl);
    endtask
    task automatic t_extra;
        frame(16'h2000, 20, 1'b0);
        `CHK("sw result", {4'h0, 12'h3C3}, got);
        `CHK("extra edges", 16'h2000, ctrl);
        `CHK("held bit", 1'b1, dout);
        frame(16'h4000, 16, 1'b0);
        `CHK("reframed", 16'h4000, ctrl);
    endtask
    task automatic t_two;
        sample = 12'h5A5;
        frame(16'h5800, 16, 1'b0);
        `CHK("two wire", 1'b1, two);
        wait_idle();
        frame(WRITE_NOP, 16, 1'b0);
        `CHK("two wire nop", 16'h4800, ctrl);
        frame(WRITE_NOP, 16, 1'b1);
        `CHK("two wire read", {4'h0, 12'h5A5}, got);
    endtask
    task automatic tally_and_finish;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_nop();
        t_fifo();
        t_sw();
        t_extra();
        t_two();
        tally_and_finish();
    end
endmodule
